// file: verilog/fcs_pkg.sv
// shared constants, types and register map of the flash command sequencer
package fcs_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // strobe low time and its count of clock cycles, rounded up
  localparam int STROBE_NS = 64;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_W = 19;
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 19'h05555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 19'h02aaa;
  // command bytes
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_CHIP_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_READ_RESET = 8'hf0;
  // controller status byte fields
  localparam int TOGGLE_BIT = 6;
  localparam int ERROR_BIT = 5;
  localparam logic [7:0] STATUS_VALID_MASK = 8'hec;
  // own register map, byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_SBYTE = 8'h14;
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h00000000;
  localparam logic [2:0] STEP_RST = 3'h0;
  localparam logic [15:0] POLL_RST = 16'h0000;
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_PROGRAM = 3'h1, OP_BLOCK_ERASE = 3'h2,
    OP_CHIP_ERASE = 3'h3, OP_SUSPEND = 3'h4, OP_RESUME = 3'h5,
    OP_RESET = 3'h6, OP_UNLOCK_RESET = 3'h7
  } fcs_op_e;
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000, SQ_WRITE = 3'b001, SQ_POLL_A = 3'b011,
    SQ_POLL_B = 3'b010, SQ_FINAL = 3'b110, SQ_READ = 3'b100
  } fcs_sq_e;
  typedef enum logic [1:0] {
    CY_IDLE = 2'b00, CY_SETUP = 2'b01, CY_STROBE = 2'b11, CY_HOLD = 2'b10
  } fcs_cy_e;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] dq;
    logic dq_oe;
    logic ce_b;
    logic oe_b;
    logic we_b;
  } fcs_pins_s;
  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } fcs_req_s;
endpackage : fcs_pkg

// file: verilog/fcs_cycle.sv
// one read or write bus cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
module fcs_cycle (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire fcs_pkg::fcs_req_s req_in,
  input wire logic [7:0] dq_in,
  output fcs_pkg::fcs_pins_s pins_out,
  output logic done_out,
  output logic [7:0] rdata_out
);
  import fcs_pkg::*;
  fcs_cy_e phase_q;
  logic [7:0] cnt_q;
  logic wr_q;
  fcs_pins_s pins_q;
  logic [7:0] rdata_q;

  assign pins_out = pins_q;
  assign rdata_out = rdata_q;
  assign done_out = (phase_q == CY_HOLD);

  // phase sequence: setup, strobe low, hold
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_q <= CY_IDLE;
      cnt_q <= BYTE_RST;
      wr_q <= 1'b0;
    end else begin
      unique case (phase_q)
        CY_IDLE: begin
          if (start_in) begin
            phase_q <= CY_SETUP;
            wr_q <= req_in.wr;
          end
        end
        CY_SETUP: begin
          phase_q <= CY_STROBE;
          cnt_q <= 8'(STROBE_CYC - 1);
        end
        CY_STROBE: begin
          if (cnt_q == BYTE_RST) begin
            phase_q <= CY_HOLD;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        CY_HOLD: begin
          phase_q <= CY_IDLE;
        end
      endcase
    end
  end

  // pin drive; each read pulses oe and ce, which steps the toggle bit
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pins_q <= '{addr: ADDR_RST, dq: BYTE_RST, dq_oe: 1'b0,
                  ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1};
    end else begin
      unique case (phase_q)
        CY_IDLE: begin
          if (start_in) begin
            pins_q.addr <= req_in.addr;
            pins_q.dq <= req_in.data;
            pins_q.dq_oe <= req_in.wr;
            pins_q.ce_b <= 1'b0;
          end
        end
        CY_SETUP: begin
          pins_q.we_b <= !wr_q;
          pins_q.oe_b <= wr_q;
        end
        CY_STROBE: begin
          if (cnt_q == BYTE_RST) begin
            pins_q.we_b <= 1'b1; // data still driven at the rising edge
            pins_q.oe_b <= 1'b1;
          end
        end
        CY_HOLD: begin
          pins_q.ce_b <= 1'b1;
          pins_q.dq_oe <= 1'b0;
        end
      endcase
    end
  end

  // capture read data at the end of the strobe
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= BYTE_RST;
    end else if (phase_q == CY_STROBE && cnt_q == BYTE_RST && !wr_q) begin
      rdata_q <= dq_in;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_no_contention: assert property (!pins_q.we_b |-> pins_q.oe_b && pins_q.dq_oe)
    else $error("write strobe without driven data or with oe low");
  a_cycle_length: assert property (phase_q == CY_IDLE && start_in
    |-> ##(STROBE_CYC + 2) done_out)
    else $error("bus cycle length wrong");
endmodule : fcs_cycle
`default_nettype wire

// file: verilog/fcs_host.sv
// flash command sequencer: ahb-lite registers to flash command cycles
// Function
// - host masks status bit positions 0, 1 and 4 as reserved
// - program is unlock, unlock, a0h at 5555h, then data at target
// - erase is two unlocks, 80h, two unlocks, then 30h block or 10h chip
// - host polls at the programmed address or inside the erased block
// - host sees completion when two reads give equal toggle bits
`timescale 1ns/1ps
`default_nettype none
module fcs_host #(
  parameter logic [15:0] POLL_LIMIT = 16'hffff
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output fcs_pkg::fcs_pins_s flash_out,
  input wire logic [7:0] flash_dq_in,
  output logic flash_rp_b_out
);
  import fcs_pkg::*;

  fcs_sq_e state_q;
  fcs_op_e op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [7:0] first_q;
  logic [2:0] step_q;
  logic [15:0] poll_cnt_q;
  logic launched_q;
  logic err_seen_q;
  logic done_q;
  logic fail_q;
  logic tmo_q;
  logic rp_b_q;
  logic ap_wr_q;
  logic [7:0] ap_addr_q;
  logic [31:0] hrdata_q;
  logic cyc_start;
  logic cyc_done;
  logic [7:0] cyc_rdata;
  fcs_req_s cyc_req;
  logic busy;
  logic go;
  logic last_step;
  logic tog_eq;
  logic ev_fail;
  logic ev_tmo;
  logic ev_fin;

  // number of command writes for each operation
  function automatic logic [2:0] step_count(input fcs_op_e op);
    logic [2:0] n;
    n = 3'h1;
    unique case (op)
      OP_PROGRAM: n = 3'h4;
      OP_BLOCK_ERASE, OP_CHIP_ERASE: n = 3'h6;
      OP_UNLOCK_RESET: n = 3'h3;
      OP_READ, OP_SUSPEND, OP_RESUME, OP_RESET: n = 3'h1;
    endcase
    return n;
  endfunction : step_count

  // operations that leave the device busy, so completion is polled
  function automatic logic needs_poll(input fcs_op_e op);
    return op inside {OP_PROGRAM, OP_BLOCK_ERASE, OP_CHIP_ERASE,
                      OP_SUSPEND, OP_RESUME};
  endfunction : needs_poll

  // address and data of one command write
  function automatic fcs_req_s step_req(input fcs_op_e op,
      input logic [2:0] s, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    fcs_req_s r;
    r = '{wr: 1'b1, addr: UNLOCK1_ADDR, data: CMD_UNLOCK1};
    if (step_count(op) == 3'h1) begin
      r.addr = a;
      r.data = (op == OP_SUSPEND) ? CMD_SUSPEND :
               (op == OP_RESUME) ? CMD_RESUME : CMD_READ_RESET;
    end else if (s == 3'h1 || s == 3'h4) begin
      r.addr = UNLOCK2_ADDR;
      r.data = CMD_UNLOCK2;
    end else if (s == 3'h2) begin
      r.data = (op == OP_PROGRAM) ? CMD_PROGRAM :
               (op == OP_UNLOCK_RESET) ? CMD_READ_RESET : CMD_ERASE_SETUP;
    end else if (s == 3'h3 && op == OP_PROGRAM) begin
      r.addr = a;
      r.data = d;
    end else if (s == 3'h5) begin
      r.addr = (op == OP_BLOCK_ERASE) ? a : UNLOCK1_ADDR;
      r.data = (op == OP_BLOCK_ERASE) ? CMD_BLOCK_CONFIRM : CMD_CHIP_CONFIRM;
    end
    return r;
  endfunction : step_req

  // bus cycle engine
  fcs_cycle u_cycle (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .start_in(cyc_start),
    .req_in(cyc_req),
    .dq_in(flash_dq_in),
    .pins_out(flash_out),
    .done_out(cyc_done),
    .rdata_out(cyc_rdata)
  );

  // sequencing terms
  assign busy = (state_q != SQ_IDLE);
  assign go = ap_wr_q && ap_addr_q == REG_CTRL && !busy;
  assign last_step = (step_q == step_count(op_q) - 3'h1);
  assign tog_eq = (first_q[TOGGLE_BIT] == cyc_rdata[TOGGLE_BIT]);
  assign cyc_start = busy && !launched_q;
  assign ev_fail = cyc_done && state_q == SQ_POLL_B && !tog_eq
                   && cyc_rdata[ERROR_BIT] && err_seen_q;
  assign ev_tmo = cyc_done && state_q == SQ_POLL_A
                  && poll_cnt_q == POLL_LIMIT;
  assign ev_fin = ev_fail || ev_tmo || (cyc_done && (state_q == SQ_FINAL
                  || state_q == SQ_READ || (state_q == SQ_WRITE
                  && last_step && !needs_poll(op_q))));

  // command writes come from the step table, reads use the target address
  always_comb begin
    cyc_req = '{wr: 1'b0, addr: addr_q, data: BYTE_RST};
    if (state_q == SQ_WRITE) begin
      cyc_req = step_req(op_q, step_q, addr_q, wdata_q);
    end
  end

  // operation state machine
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= SQ_IDLE;
      op_q <= OP_READ;
      step_q <= STEP_RST;
    end else begin
      unique case (state_q)
        SQ_IDLE: begin
          if (go) begin
            op_q <= fcs_op_e'(hwdata_in[2:0]);
            step_q <= STEP_RST;
            state_q <= (hwdata_in[2:0] == OP_READ) ? SQ_READ : SQ_WRITE;
          end
        end
        SQ_WRITE: begin
          if (cyc_done) begin
            step_q <= step_q + 3'h1;
            if (last_step) begin
              // status is only meaningful after the last command write
              state_q <= needs_poll(op_q) ? SQ_POLL_A : SQ_IDLE;
            end
          end
        end
        SQ_POLL_A: begin
          if (cyc_done) begin
            state_q <= ev_tmo ? SQ_IDLE : SQ_POLL_B;
          end
        end
        SQ_POLL_B: begin
          if (cyc_done) begin
            if (tog_eq) begin
              state_q <= SQ_FINAL;
            end else if (ev_fail) begin
              state_q <= SQ_IDLE;
            end else begin
              state_q <= SQ_POLL_A;
            end
          end
        end
        SQ_FINAL, SQ_READ: begin
          if (cyc_done) begin
            state_q <= SQ_IDLE;
          end
        end
        default: begin
          state_q <= SQ_IDLE;
        end
      endcase
    end
  end

  // one bus cycle launched per step
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      launched_q <= 1'b0;
    end else if (cyc_done) begin
      launched_q <= 1'b0;
    end else if (cyc_start) begin
      launched_q <= 1'b1;
    end
  end

  // toggle pair tracking, error retry and poll count
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      first_q <= BYTE_RST;
      err_seen_q <= 1'b0;
      poll_cnt_q <= POLL_RST;
    end else if (go) begin
      err_seen_q <= 1'b0;
      poll_cnt_q <= POLL_RST;
    end else if (cyc_done && state_q == SQ_POLL_A) begin
      first_q <= cyc_rdata;
      poll_cnt_q <= poll_cnt_q + 16'h0001;
    end else if (cyc_done && state_q == SQ_POLL_B && !tog_eq) begin
      // error bit seen while toggling: one more pair decides failure
      err_seen_q <= err_seen_q | cyc_rdata[ERROR_BIT];
    end
  end

  // last byte read from the device
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q <= BYTE_RST;
    end else if (cyc_done && !cyc_req.wr) begin
      rdata_q <= cyc_rdata;
    end
  end

  // sticky status flags; completion wins over a software clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
      tmo_q <= 1'b0;
    end else begin
      if (ev_fin) begin
        done_q <= 1'b1;
      end else if (ap_wr_q && ap_addr_q == REG_STATUS && hwdata_in[1]) begin
        done_q <= 1'b0;
      end
      if (go) begin
        fail_q <= 1'b0;
        tmo_q <= 1'b0;
      end else begin
        fail_q <= fail_q | ev_fail;
        tmo_q <= tmo_q | ev_tmo;
      end
    end
  end

  // reset pin released one clock after controller reset
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rp_b_q <= 1'b0;
    end else begin
      rp_b_q <= 1'b1;
    end
  end
  assign flash_rp_b_out = rp_b_q;

  // ahb-lite address phase capture and registered read data
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= BYTE_RST;
      hrdata_q <= WORD_RST;
    end else begin
      ap_wr_q <= 1'b0;
      if (hsel_in && htrans_in[1] && hready_in) begin
        ap_wr_q <= hwrite_in && hsize_in == 3'b010;
        ap_addr_q <= haddr_in[7:0];
        hrdata_q <= WORD_RST;
        if (!hwrite_in && haddr_in[31:8] == 24'h000000) begin
          unique case (haddr_in[7:0])
            REG_CTRL: hrdata_q <= {29'h0, op_q};
            REG_ADDR: hrdata_q <= {13'h0, addr_q};
            REG_WDATA: hrdata_q <= {24'h0, wdata_q};
            REG_STATUS: hrdata_q <= {28'h0, tmo_q, fail_q, done_q, busy};
            REG_RDATA: hrdata_q <= {24'h0, rdata_q};
            REG_SBYTE: hrdata_q <= {24'h0, rdata_q & STATUS_VALID_MASK};
            default: hrdata_q <= WORD_RST;
          endcase
        end
      end
    end
  end
  assign hrdata_out = hrdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  // target address and data, frozen while an operation runs
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_q <= ADDR_RST;
      wdata_q <= BYTE_RST;
    end else if (ap_wr_q && !busy) begin
      if (ap_addr_q == REG_ADDR) begin
        addr_q <= hwdata_in[ADDR_W-1:0];
      end
      if (ap_addr_q == REG_WDATA) begin
        wdata_q <= hwdata_in[7:0];
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_unlock_first: assert property (cyc_start && state_q == SQ_WRITE
    && step_q == 3'h0 && step_count(op_q) != 3'h1
    |-> cyc_req.addr == UNLOCK1_ADDR && cyc_req.data == CMD_UNLOCK1)
    else $error("first command write is not the unlock");
  a_prog_cmd: assert property (cyc_start && state_q == SQ_WRITE
    && op_q == OP_PROGRAM && step_q == 3'h2
    |-> cyc_req.addr == UNLOCK1_ADDR && cyc_req.data == CMD_PROGRAM)
    else $error("program command byte wrong");
  a_prog_data: assert property (cyc_start && state_q == SQ_WRITE
    && op_q == OP_PROGRAM && step_q == 3'h3
    |-> cyc_req.addr == addr_q && cyc_req.data == wdata_q)
    else $error("program data write wrong");
  a_erase_setup: assert property (cyc_start && state_q == SQ_WRITE
    && op_q inside {OP_BLOCK_ERASE, OP_CHIP_ERASE} && step_q == 3'h2
    |-> cyc_req.data == CMD_ERASE_SETUP)
    else $error("erase setup byte wrong");
  a_erase_confirm: assert property (cyc_start && state_q == SQ_WRITE
    && step_q == 3'h5 |-> (op_q == OP_BLOCK_ERASE) ?
    (cyc_req.addr == addr_q && cyc_req.data == CMD_BLOCK_CONFIRM) :
    (cyc_req.addr == UNLOCK1_ADDR && cyc_req.data == CMD_CHIP_CONFIRM))
    else $error("erase confirm write wrong");
  a_poll_address: assert property (state_q inside {SQ_POLL_A, SQ_POLL_B}
    && cyc_start |=> flash_out.addr == addr_q)
    else $error("polling read not at target address");
  a_toggle_done: assert property (state_q == SQ_POLL_B && cyc_done && tog_eq
    |=> state_q == SQ_FINAL ##[1:20] done_q)
    else $error("equal toggle pair did not finish");
  a_status_mask: assert property (hsel_in && htrans_in[1] && hready_in
    && !hwrite_in && haddr_in == {24'h0, REG_SBYTE}
    |=> hrdata_out[4] == 1'b0 && hrdata_out[1:0] == 2'b00)
    else $error("reserved status bits not masked");
  c_program: cover property (state_q == SQ_FINAL && op_q == OP_PROGRAM
    && cyc_done);
  c_erase: cover property (state_q == SQ_FINAL && op_q == OP_CHIP_ERASE
    && cyc_done);
  c_fail: cover property (ev_fail);
endmodule : fcs_host
`default_nettype wire

// file: bench/fcs_flash_model.sv
// behavioural flash device seen from the command sequencer's pins
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model (
  input wire fcs_pkg::fcs_pins_s pins_in,
  input wire logic rp_b_in,
  input wire logic fail_in,
  input wire logic [7:0] slow_in,
  output logic [7:0] dq_out
);
  import fcs_pkg::*;
  localparam logic [2:0] PROT_BLK = 3'h7;
  logic [7:0] mem [int];
  logic [7:0] pd, r, pl, el;
  logic [18:0] pa;
  logic [2:0] eb, step;
  logic tog, tog2, err, susp, chip;
  // array view: bytes never programmed read as erased
  function automatic logic [7:0] arr(input logic [18:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hff;
  endfunction : arr
  // erase clears the chosen block or the whole array
  task automatic wipe();
    int ks[$];
    foreach (mem[k]) begin
      if (chip || k[18:16] == eb) ks.push_back(k);
    end
    foreach (ks[i]) mem.delete(ks[i]);
  endtask : wipe
  // command decoder; any stray write drops the sequence
  task automatic cmd(input logic [18:0] a, input logic [7:0] d);
    logic ul;
    ul = (a == UNLOCK1_ADDR);
    if (d == CMD_READ_RESET && (step == 3'h0 || (step == 3'h2 && ul))) begin
      {step, pl, el, err, susp} = '0;
    end else if (el != 8'h0 && !susp && pl == 8'h0) begin
      susp = (d == CMD_SUSPEND);
      step = 3'h0;
    end else if (susp && step == 3'h0 && d == CMD_RESUME) begin
      susp = 1'b0;
    end else if ((step == 3'h0 || step == 3'h4) && ul && d == CMD_UNLOCK1) begin
      step = step + 3'h1;
    end else if ((step == 3'h1 || step == 3'h5) && a == UNLOCK2_ADDR &&
                 d == CMD_UNLOCK2) begin
      step = step + 3'h1;
    end else if (step == 3'h2 && ul && d == CMD_PROGRAM) begin
      step = 3'h3;
    end else if (step == 3'h2 && ul && d == CMD_ERASE_SETUP && !susp) begin
      step = 3'h4;
    end else if (step == 3'h3) begin
      pa = a;
      pd = d;
      pl = slow_in;
      step = 3'h0;
    end else if (step == 3'h6 && (d == CMD_BLOCK_CONFIRM ||
                 (ul && d == CMD_CHIP_CONFIRM))) begin
      chip = (d == CMD_CHIP_CONFIRM);
      eb = a[18:16];
      el = slow_in;
      step = 3'h0;
    end else begin
      step = 3'h0;
    end
  endtask : cmd
  // one read: status while busy or inside a suspended erase block, array data otherwise
  task automatic rd(input logic [18:0] a);
    logic inb;
    inb = (a[18:16] == eb) || chip;
    if (pl != 8'h0) begin
      r = {~pd[7], tog, err, 5'b10111};
      tog = ~tog;
      if (fail_in) err = 1'b1;
      else pl = pl - 8'h1;
      if (!fail_in && pl == 8'h0) mem[int'(pa)] = arr(pa) & pd;
    end else if (el != 8'h0 && !susp) begin
      r = {1'b0, tog, err, 2'b11, inb ? tog2 : 1'b1, 2'b11};
      tog = ~tog;
      tog2 = tog2 ^ inb;
      el = el - 8'h1;
      if (el == 8'h0 && (chip || eb != PROT_BLK)) wipe();
    end else if (susp && inb) begin
      r = {3'b110, 2'b10, tog2, 2'b11};
      tog2 = ~tog2;
    end else begin
      r = arr(a);
    end
    dq_out = r;
  endtask : rd
  // write strobe rising latches a command; reset pin clears the command and status state, not the array
  always @(posedge pins_in.we_b or negedge rp_b_in) begin
    if (!rp_b_in) begin
      {step, pl, el, err, susp, tog, tog2, chip, r} = '0;
    end else if (!pins_in.ce_b) begin
      cmd(pins_in.addr, pins_in.dq);
    end
  end
  // output strobe, or select while strobe low, marks a read
  always @(negedge pins_in.oe_b or negedge pins_in.ce_b) begin
    if (rp_b_in && !pins_in.oe_b && !pins_in.ce_b) rd(pins_in.addr);
  end
  // released bus shows no stale byte
  always @(posedge pins_in.oe_b or posedge pins_in.ce_b) begin
    dq_out = ~r;
  end
endmodule : fcs_flash_model
`default_nettype wire

// file: bench/tb_fcs_host.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_fcs_host;
  import fcs_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, rd_dp = 1'b0, fail = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r, e, m;
  logic hready, hresp, rp_b;
  logic [7:0] slow = 8'h3, mdq, dq_w, x, y, z;
  logic [18:0] a, b, c;
  fcs_pins_s flash;
  logic [31:0] exp_q[$], msk_q[$];
  int fail_count = 0, tests_run = 0, cyc = 0;
  // clock and wire level of the shared data bus
  always #4 clk_in = ~clk_in;
  assign dq_w = flash.dq_oe ? flash.dq : mdq;
  fcs_host #(.POLL_LIMIT(16'd8)) i_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hready_in(hready), .hwdata_in(hwdata),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .flash_out(flash), .flash_dq_in(dq_w), .flash_rp_b_out(rp_b));
  fcs_flash_model i_mem (.pins_in(flash), .rp_b_in(rp_b),
    .fail_in(fail), .slow_in(slow), .dq_out(mdq));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  // result watcher: each read data phase meets the oldest note
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      close_out();
    end else if (rd_dp && hready) begin
      // every read data phase must answer okay
      if (hresp !== 1'b0) begin
        fail_count++;
        $display("MISMATCH t=%0t hresp %h exp %h", $time, hresp, 1'b0);
      end
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 32'h0) begin
        tests_run++;
        if (((hrdata ^ e) & m) !== 32'h0) begin
          fail_count++;
          $display("MISMATCH t=%0t got %h exp %h", $time, hrdata, e);
        end
      end
    end
  end
  // one ahb-lite single transfer; reads note their expectation
  task automatic ahb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, ev, mv);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rd_dp <= !w;
    if (!w) begin
      exp_q.push_back(ev);
      msk_q.push_back(mv);
    end
    @(posedge clk_in);
    while (hready !== 1'b1) @(posedge clk_in);
    r = hrdata;
    rd_dp <= 1'b0;
  endtask : ahb
  // start an operation, wait for done, check and clear status
  task automatic run_op(input logic [2:0] op, input logic [18:0] ad,
                        input logic [7:0] d, input logic [31:0] st);
    int n;
    ahb(1'b1, REG_ADDR, {13'h0, ad}, 32'h0, 32'h0);
    ahb(1'b1, REG_WDATA, {24'h0, d}, 32'h0, 32'h0);
    ahb(1'b1, REG_CTRL, {29'h0, op}, 32'h0, 32'h0);
    n = 0;
    do begin
      ahb(1'b0, REG_STATUS, 32'h0, 32'h0, 32'h0);
      n++;
    end while (r[1] !== 1'b1 && n < 4000);
    ahb(1'b0, REG_STATUS, 32'h0, st, 32'hffffffff);
    ahb(1'b1, REG_STATUS, 32'h2, 32'h0, 32'h0);
    ahb(1'b0, REG_STATUS, 32'h0, 32'h0, 32'h3);
  endtask : run_op
  // read one byte of the array through the sequencer
  task automatic chk(input logic [18:0] ad, input logic [7:0] d);
    run_op(3'h0, ad, 8'h0, 32'h2);
    ahb(1'b0, REG_RDATA, 32'h0, {24'h0, d}, 32'hffffffff);
  endtask : chk
  initial begin
    void'($urandom(12));
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    ahb(1'b0, REG_STATUS, 32'h0, 32'h0, 32'hffffffff);
    ahb(1'b0, REG_SBYTE, 32'h0, 32'h0, 32'hffffffff);
    ahb(1'b1, 8'h18, 32'hffffffff, 32'h0, 32'h0);
    ahb(1'b0, 8'h18, 32'h0, 32'h0, 32'hffffffff);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      a = {3'h1, 4'(i), 12'($urandom)};
      x = 8'($urandom);
      run_op(3'h1, a, x, 32'h2);
      chk(a, x);
      ahb(1'b0, REG_SBYTE, 32'h0, {24'h0, x & STATUS_VALID_MASK}, 32'hff);
    end
    $display("test program done");
    run_op(3'h2, {3'h1, 16'h0}, 8'h0, 32'h2);
    chk(a, 8'hff);
    b = {3'h2, 16'($urandom)};
    run_op(3'h1, b, 8'h00, 32'h2);
    run_op(3'h3, UNLOCK1_ADDR, 8'h0, 32'h2);
    chk(b, 8'hff);
    c = {3'h7, 16'($urandom)};
    run_op(3'h1, c, 8'h5a, 32'h2);
    run_op(3'h2, c, 8'h0, 32'h2);
    chk(c, 8'h5a);
    $display("test erase done");
    fail <= 1'b1;
    run_op(3'h1, a, 8'h0f, 32'h6);
    ahb(1'b0, REG_SBYTE, 32'h0, 32'h24, 32'h37);
    fail <= 1'b0;
    run_op(3'h6, a, 8'h0, 32'h2);
    chk(a, 8'hff);
    run_op(3'h7, a, 8'h0, 32'h2);
    chk(a, 8'hff);
    $display("test fail and reset done");
    a = {3'h3, 16'($urandom)};
    b = {3'h4, 16'($urandom)};
    y = 8'($urandom);
    run_op(3'h1, a, 8'h00, 32'h2);
    run_op(3'h1, b, y, 32'h2);
    slow <= 8'd24;
    run_op(3'h2, a, 8'h0, 32'ha);
    ahb(1'b0, REG_SBYTE, 32'h0, 32'h08, 32'hab);
    run_op(3'h4, a, 8'h0, 32'h2);
    ahb(1'b0, REG_SBYTE, 32'h0, 32'hc0, 32'hf3);
    chk(b, y);
    slow <= 8'h3;
    c = {3'h5, 16'($urandom)};
    z = 8'($urandom);
    run_op(3'h1, c, z, 32'h2);
    chk(c, z);
    run_op(3'h5, a, 8'h0, 32'h2);
    chk(a, 8'hff);
    chk(b, y);
    $display("test suspend done");
    close_out();
  end
endmodule : tb_fcs_host
`default_nettype wire
